// file: hw/nsa_pkg.sv
package nsa_pkg;

    // ------------------------------------------------------------------
    // Register map (index on reg_addr_in)
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_CTRL  = 3'h0;
    localparam logic [2:0] REG_TRIG  = 3'h1;
    localparam logic [2:0] REG_START = 3'h2;
    localparam logic [2:0] REG_END   = 3'h3;
    localparam logic [2:0] REG_PTR   = 3'h4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_INTERRUPT_PAUSE_SELECT_BIT = 3;
    localparam int CTRL_BUSY_BIT = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic       GO_RST   = 1'b0;
    localparam logic       INTERRUPT_PAUSE_SELECT_RST = 1'b0;
    localparam logic [1:0] TRIG_RST = 2'h0;

    // Mode field encodings are fixed by the register layout
    typedef enum logic [1:0] {
        NSA_CONCURRENT = 2'h0,
        NSA_BURST      = 2'h1,
        NSA_PEEK       = 2'h2,
        NSA_TRIGGERED  = 2'h3
    } nsa_mode_t;

    localparam nsa_mode_t MODE_RST = NSA_CONCURRENT;

    typedef enum logic [1:0] {
        NSA_IDLE,
        NSA_WAIT_TRIG,
        NSA_RUN
    } nsa_state_t;

endpackage

// file: hw/nsa_trig_if.sv
`timescale 1ns/1ps
interface nsa_trig_if #(
    parameter int N = 4
);
    logic [N-1:0] raw;
    logic [N-1:0] rise;

    modport sync (input raw, output rise);
    modport core (output raw, input rise);
endinterface

// file: hw/nsa_trig_sync.sv
`timescale 1ns/1ps
module nsa_trig_sync #(
    parameter int N = 4
) (
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    nsa_trig_if.sync  tif
);
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] lvl_r;
    logic [N-1:0] rise_r;
    wire  [N-1:0] agree = ~(s2_r ^ s3_r);
    wire  [N-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);

    // A level counts only once the second and third stages agree
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            lvl_r  <= '0;
            rise_r <= '0;
        end else begin
            s1_r   <= tif.raw;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            lvl_r  <= lvl_nxt;
            rise_r <= lvl_nxt & ~lvl_r;
        end
    end

    assign tif.rise = rise_r;
endmodule // nsa_trig_sync

// file: hw/nsa_scanner.sv
`timescale 1ns/1ps
// Overview of operation
// - Burst: stall CPU from next operation
// - Burst stall lasts until hardware end
// - Concurrent: stall only on scanner accesses
// - Triggered: wait for selected trigger edge
// - Peek: use only CPU dead cycles
// - Pause select set: interrupt pauses burst
// - Pause select set: suspend other modes
// - Pause clear: burst delays interrupt response
// - Pause clear: accesses continue during interrupt
module nsa_scanner #(
    parameter int AW    = 15,
    parameter int DW    = 14,
    parameter int NTRIG = 4
) (
    input  wire logic          mclk_in,
    input  wire logic          sys_rst_in,
    input  wire logic [2:0]    reg_addr_in,
    input  wire logic [15:0]   reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic      [15:0]   reg_rdata_out,
    input  wire logic [NTRIG-1:0] trig_clk_in,
    input  wire logic          cpu_mem_req_in,
    input  wire logic [AW-1:0] cpu_mem_addr_in,
    input  wire logic          irq_pending_in,
    input  wire logic          irq_active_in,
    output logic               cpu_stall_out,
    output logic               irq_hold_out,
    output logic      [AW-1:0] nvm_addr_out,
    input  wire logic [DW-1:0] nvm_rdata_in,
    output logic      [DW-1:0] scan_data_out,
    output logic               scan_valid_out
);
    // ------------------------------------------------------------------
    // Trigger clock synchroniser
    // ------------------------------------------------------------------
    nsa_trig_if #(.N(NTRIG)) tif ();
    assign tif.raw = trig_clk_in;

    nsa_trig_sync #(.N(NTRIG)) u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .tif        (tif)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nsa_pkg::nsa_state_t state_r;
    nsa_pkg::nsa_mode_t  mode_r;
    logic                go_r;
    logic                interrupt_pause_select_r;
    logic [1:0]          trig_sel_r;
    logic [AW-1:0]       start_r;
    logic [AW-1:0]       end_r;
    logic [AW-1:0]       ptr_r;
    logic                gap_r;
    logic                acc_d_r;
    logic [15:0]         rdata_r;
    logic [DW-1:0]       sdata_r;
    logic                svalid_r;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_ctrl  = reg_wr_in && (reg_addr_in == nsa_pkg::REG_CTRL);
    wire wr_trig  = reg_wr_in && (reg_addr_in == nsa_pkg::REG_TRIG);
    wire wr_start = reg_wr_in && (reg_addr_in == nsa_pkg::REG_START);
    wire wr_end   = reg_wr_in && (reg_addr_in == nsa_pkg::REG_END);
    wire go_wbit  = reg_wdata_in[nsa_pkg::CTRL_GO_BIT];
    wire go_set   = wr_ctrl && go_wbit;
    wire go_clr   = wr_ctrl && !go_wbit;
    wire nsa_pkg::nsa_mode_t mode_w =
        nsa_pkg::nsa_mode_t'(reg_wdata_in[nsa_pkg::CTRL_MODE_LSB +: 2]);

    // ------------------------------------------------------------------
    // Access arbitration
    // ------------------------------------------------------------------
    wire is_burst = (mode_r == nsa_pkg::NSA_BURST);
    wire is_peek  = (mode_r == nsa_pkg::NSA_PEEK);
    wire running  = (state_r == nsa_pkg::NSA_RUN);
    // A pending interrupt must pause too, or a stalled core never takes it
    wire pause    = interrupt_pause_select_r && (irq_pending_in || irq_active_in);
    wire trig_hit = tif.rise[trig_sel_r];
    // Peek steals dead cycles; concurrent modes leave a gap after each access
    wire slot_ok  = is_burst ? 1'b1 : (is_peek ? !cpu_mem_req_in : !gap_r);
    wire access   = running && !pause && slot_ok;
    wire last     = access && (ptr_r == end_r);
    wire conc_acc = access && !is_burst && !is_peek;

    assign cpu_stall_out = (running && is_burst && !pause) || conc_acc;
    assign irq_hold_out  = running && is_burst && !interrupt_pause_select_r;
    assign nvm_addr_out  = access ? ptr_r : cpu_mem_addr_in;

    wire [15:0] ctrl_rd = {8'h00, (state_r != nsa_pkg::NSA_IDLE), 3'h0,
                           interrupt_pause_select_r, mode_r, go_r};
    wire [15:0] rd_mux =
        (reg_addr_in == nsa_pkg::REG_CTRL)  ? ctrl_rd :
        (reg_addr_in == nsa_pkg::REG_TRIG)  ? {14'h0000, trig_sel_r} :
        (reg_addr_in == nsa_pkg::REG_START) ? 16'(start_r) :
        (reg_addr_in == nsa_pkg::REG_END)   ? 16'(end_r) :
        (reg_addr_in == nsa_pkg::REG_PTR)   ? 16'(ptr_r) : 16'h0000;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    nsa_pkg::nsa_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        if (go_set) begin
            state_nxt = (mode_w == nsa_pkg::NSA_TRIGGERED) ?
                        nsa_pkg::NSA_WAIT_TRIG : nsa_pkg::NSA_RUN;
        end else if (go_clr) begin
            state_nxt = nsa_pkg::NSA_IDLE;
        end else begin
            unique case (state_r)
                nsa_pkg::NSA_IDLE: begin
                    state_nxt = nsa_pkg::NSA_IDLE;
                end
                nsa_pkg::NSA_WAIT_TRIG: begin
                    if (trig_hit) begin
                        state_nxt = nsa_pkg::NSA_RUN;
                    end
                end
                nsa_pkg::NSA_RUN: begin
                    if (last) begin
                        state_nxt = nsa_pkg::NSA_IDLE;
                    end
                end
                default: begin
                    state_nxt = nsa_pkg::NSA_IDLE;
                end
            endcase
        end
    end

    // A software set in the end cycle wins over the hardware clear
    wire go_nxt = wr_ctrl ? go_wbit : (last ? 1'b0 : go_r);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_r    <= nsa_pkg::NSA_IDLE;
            mode_r     <= nsa_pkg::MODE_RST;
            go_r       <= nsa_pkg::GO_RST;
            interrupt_pause_select_r     <= nsa_pkg::INTERRUPT_PAUSE_SELECT_RST;
            trig_sel_r <= nsa_pkg::TRIG_RST;
            start_r    <= '0;
            end_r      <= '0;
        end else begin
            state_r <= state_nxt;
            go_r    <= go_nxt;
            if (wr_ctrl) begin
                mode_r <= mode_w;
                interrupt_pause_select_r <= reg_wdata_in[nsa_pkg::CTRL_INTERRUPT_PAUSE_SELECT_BIT];
            end
            if (wr_trig) begin
                trig_sel_r <= reg_wdata_in[1:0];
            end
            if (wr_start) begin
                start_r <= reg_wdata_in[AW-1:0];
            end
            if (wr_end) begin
                end_r <= reg_wdata_in[AW-1:0];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ptr_r <= '0;
            gap_r <= 1'b0;
        end else if (go_set) begin
            ptr_r <= start_r;
            gap_r <= 1'b0;
        end else begin
            ptr_r <= access ? ptr_r + AW'(1) : ptr_r;
            gap_r <= access;
        end
    end

    // Memory answers one cycle after the address; data leaves registered
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            acc_d_r  <= 1'b0;
            sdata_r  <= '0;
            svalid_r <= 1'b0;
            rdata_r  <= 16'h0000;
        end else begin
            acc_d_r  <= access;
            svalid_r <= acc_d_r;
            if (acc_d_r) begin
                sdata_r <= nvm_rdata_in;
            end
            rdata_r <= reg_rd_in ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata_out  = rdata_r;
    assign scan_data_out  = sdata_r;
    assign scan_valid_out = svalid_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_burst_go;
        go_set && (mode_w == nsa_pkg::NSA_BURST) && !reg_wdata_in[nsa_pkg::CTRL_INTERRUPT_PAUSE_SELECT_BIT];
    endsequence

    sequence s_burst_stalled;
        cpu_stall_out && is_burst && !last && !wr_ctrl;
    endsequence

    sequence s_end_seen;
        last && !wr_ctrl;
    endsequence

    a_burst_stall_next: assert property (
        s_burst_go |=> cpu_stall_out || pause)
        else $error("burst did not stall the cycle after go");

    a_burst_stall_hold: assert property (
        s_burst_stalled |=> running && (cpu_stall_out || pause))
        else $error("burst stall dropped before scan end");

    a_conc_gap_after: assert property (
        conc_acc && !go_set |=> !access)
        else $error("concurrent access without a CPU gap");

    a_trig_wait_edge: assert property (
        (state_r == nsa_pkg::NSA_WAIT_TRIG) && !trig_hit && !wr_ctrl |=> !access)
        else $error("triggered scan started without trigger edge");

    a_peek_no_impact: assert property (
        access && is_peek |-> !cpu_mem_req_in && !cpu_stall_out)
        else $error("peek access collided with CPU");

    a_pause_burst_irq: assert property (
        interrupt_pause_select_r && is_burst && irq_active_in |-> !cpu_stall_out && !irq_hold_out)
        else $error("burst not paused for interrupt");

    a_pause_scan_irq: assert property (
        interrupt_pause_select_r && irq_active_in && !is_burst |-> !access && !cpu_stall_out)
        else $error("scan not suspended during interrupt");

    a_burst_hold_irq: assert property (
        running && is_burst && !interrupt_pause_select_r |-> irq_hold_out && cpu_stall_out)
        else $error("interrupt not delayed during burst");

    a_conc_irq_cont: assert property (
        running && !interrupt_pause_select_r && !is_burst && !is_peek && !gap_r |-> access)
        else $error("concurrent access lost during interrupt");

    // A go write in the idle cycle may legally restart the scan at once
    a_end_clears_go: assert property (
        s_end_seen |=> (!go_r && (state_r == nsa_pkg::NSA_IDLE))
                       ##1 (!access || $past(go_set)))
        else $error("go not cleared at scan end");

    sequence s_trig_fire;
        (state_r == nsa_pkg::NSA_WAIT_TRIG) && trig_hit && !wr_ctrl;
    endsequence

    a_trig_edge_run: assert property (
        s_trig_fire |=> running)
        else $error("trigger edge did not start the scan");

    a_acc_on_ptr: assert property (
        access |-> (nvm_addr_out == ptr_r))
        else $error("scanner access not on scan pointer");

    a_word_two_late: assert property (
        access |-> ##2 (scan_valid_out && (scan_data_out == $past(nvm_rdata_in))))
        else $error("scan word not delivered two cycles after access");

    a_conc_no_stall: assert property (
        !is_burst && !access |-> !cpu_stall_out)
        else $error("CPU stalled outside a scanner access");

    a_peek_slot_used: assert property (
        running && is_peek && !pause && !cpu_mem_req_in |-> access)
        else $error("peek mode skipped a dead cycle");

    a_idle_no_stall: assert property (
        !running |-> !cpu_stall_out && !irq_hold_out)
        else $error("stall or interrupt hold while not scanning");

    a_burst_resume: assert property (
        running && is_burst && !pause |-> access && cpu_stall_out)
        else $error("burst did not run while unpaused");

    a_conc_hold_off: assert property (
        !is_burst |-> !irq_hold_out)
        else $error("interrupt delayed outside burst mode");

endmodule // nsa_scanner

// file: tb/nsa_cpu_model.sv
`timescale 1ns/1ps
module nsa_cpu_model #(
    parameter int AW = 15,
    parameter int DW = 14
) (
    input  wire logic          mclk_in,
    input  wire logic          sys_rst_in,
    input  wire logic          busy_in,
    input  wire logic          stall_in,
    input  wire logic [AW-1:0] nvm_addr_in,
    output logic               mem_req_out,
    output logic      [AW-1:0] mem_addr_out,
    output logic      [DW-1:0] nvm_rdata_out
);
    // ------------------------------------------------------------------
    // Core fetch and memory array
    // ------------------------------------------------------------------
    assign mem_req_out = busy_in;
    // The core only moves on when it was not held, like a real fetch unit
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mem_addr_out <= '0;
        end else if (busy_in && !stall_in) begin
            mem_addr_out <= mem_addr_out + AW'(1);
        end
        nvm_rdata_out <= nvm_addr_in[DW-1:0] ^ 14'h2A5A;
    end
endmodule // nsa_cpu_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  trig = 4'h0;
    logic        busy = 1'b0;
    logic        irq_pend = 1'b0;
    logic        irq_act = 1'b0;
    logic        mem_req, stall, hold, valid;
    logic [14:0] mem_addr, nvm_addr;
    logic [13:0] nvm_rdata, sdata;
    int          mismatches = 0;
    int          compares = 0;

    always #5 mclk_in = ~mclk_in;

    nsa_scanner i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .trig_clk_in(trig), .cpu_mem_req_in(mem_req),
        .cpu_mem_addr_in(mem_addr), .irq_pending_in(irq_pend), .irq_active_in(irq_act),
        .cpu_stall_out(stall), .irq_hold_out(hold), .nvm_addr_out(nvm_addr),
        .nvm_rdata_in(nvm_rdata), .scan_data_out(sdata), .scan_valid_out(valid));

    nsa_cpu_model i_cpu (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .busy_in(busy),
        .stall_in(stall), .nvm_addr_in(nvm_addr), .mem_req_out(mem_req),
        .mem_addr_out(mem_addr), .nvm_rdata_out(nvm_rdata));

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [13:0] exp_word(input logic [14:0] a);
        return a[13:0] ^ 14'h2A5A;
    endfunction

    // Counts cycles with a valid scan word or a stall; both must stay at 0
    task automatic quiet(input int n, output int bad);
        bad = 0;
        repeat (n) begin
            @(negedge mclk_in);
            if (valid !== 1'b0 || stall !== 1'b0) bad++;
        end
    endtask

    // Follows a two-word scan from START 2 to END 3, bounded
    task automatic watch(output int ns, output int mr);
        int nv;
        int run;
        logic [15:0] c;
        nv = 0;
        ns = 0;
        mr = 0;
        run = 0;
        for (int i = 0; i < 300 && nv < 2; i++) begin
            @(negedge mclk_in);
            run = (stall === 1'b1) ? run + 1 : 0;
            if (stall === 1'b1) ns++;
            if (run > mr) mr = run;
            if (valid === 1'b1) begin
                chk("scan_data", 16'(sdata), 16'(exp_word(15'(2 + nv))));
                nv++;
            end
        end
        chk("scan_words", 16'(nv), 16'h0002);
        if (nv < 2) tally_and_finish();
        repeat (2) @(posedge mclk_in);
        rd(nsa_pkg::REG_CTRL, c);
        chk("go_busy_after_end", c & 16'h0081, 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_burst;
        int ns, mr;
        irq_pend <= 1'b1;
        wr(nsa_pkg::REG_CTRL, 16'h0003);
        #1;
        chk("burst_first_stall", 16'(stall), 16'h0001);
        chk("burst_hold", 16'(hold), 16'h0001);
        chk("burst_addr", 16'(nvm_addr), 16'h0002);
        watch(ns, mr);
        chk("burst_run", 16'(mr), 16'h0002);
        @(posedge mclk_in);
        irq_pend <= 1'b0;
    endtask

    task automatic t_conc(input logic irq);
        int ns, mr;
        @(posedge mclk_in);
        irq_act <= irq;
        wr(nsa_pkg::REG_CTRL, 16'h0001);
        watch(ns, mr);
        chk("conc_stalls", 16'(ns), 16'h0002);
        chk("conc_run", 16'(mr), 16'h0001);
        @(posedge mclk_in);
        irq_act <= 1'b0;
    endtask

    task automatic t_peek;
        int ns, mr, b;
        @(posedge mclk_in);
        busy <= 1'b1;
        wr(nsa_pkg::REG_CTRL, 16'h0005);
        quiet(20, b);
        chk("peek_while_busy", 16'(b), 16'h0000);
        @(posedge mclk_in);
        busy <= 1'b0;
        watch(ns, mr);
        chk("peek_stalls", 16'(ns), 16'h0000);
    endtask

    task automatic t_trig;
        int ns, mr, b;
        wr(nsa_pkg::REG_TRIG, 16'h0001);
        wr(nsa_pkg::REG_CTRL, 16'h0007);
        trig <= 4'h1;
        quiet(15, b);
        chk("trig_wait", 16'(b), 16'h0000);
        @(posedge mclk_in);
        trig <= 4'h3;
        watch(ns, mr);
        chk("trig_run", 16'(mr), 16'h0001);
        @(posedge mclk_in);
        trig <= 4'h0;
    endtask

    task automatic t_pause(input logic [15:0] ctrl, input int runs);
        int ns, mr, b;
        @(posedge mclk_in);
        irq_act <= 1'b1;
        wr(nsa_pkg::REG_CTRL, ctrl);
        quiet(12, b);
        chk("paused", 16'(b), 16'h0000);
        chk("pause_hold", 16'(hold), 16'h0000);
        @(posedge mclk_in);
        irq_act <= 1'b0;
        watch(ns, mr);
        chk("resumed", 16'(mr), 16'(runs));
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        logic [15:0] v;
        repeat (12) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(nsa_pkg::REG_CTRL, v);
        chk("ctrl_reset", v, 16'h0000);
        wr(3'h5, 16'hFFFF);
        rd(3'h5, v);
        chk("unmapped", v, 16'h0000);
        wr(nsa_pkg::REG_START, 16'h0002);
        wr(nsa_pkg::REG_END, 16'h0003);
        t_burst();
        t_conc(1'b0);
        t_conc(1'b1);
        t_peek();
        t_trig();
        t_pause(16'h0009, 1);
        t_pause(16'h000B, 2);
        tally_and_finish();
    end
endmodule // tb
